/* cdcs_defines.svh */
`ifndef CDCS_DEFINES_SVH
`define CDCS_DEFINES_SVH

// Timing
`define CDCS_CLK_HZ 20000000
`define CDCS_SAMPLE_HZ 250000
`define CDCS_SAMPLE_CYCLES (`CDCS_CLK_HZ / `CDCS_SAMPLE_HZ)
`define CDCS_LP_STEP_MS 200
`define CDCS_LP_STEP_CYCLES (`CDCS_CLK_HZ / 1000 * `CDCS_LP_STEP_MS)

// Decimation and filter
`define CDCS_DECIM_256 256
`define CDCS_DECIM_128 128
`define CDCS_DECIM_64 64
`define CDCS_AVG_FACTOR 3
`define CDCS_FULL_SCALE 65535
`define CDCS_FRAC_BITS 16

// Register addresses; a page is address bits 11:5, stage index is bits 4:2
`define CDCS_CTRL_ADDR 12'h000
`define CDCS_CAL_ADDR 12'h004
`define CDCS_THR_ADDR 12'h008
`define CDCS_STAT_ADDR 12'h00c
`define CDCS_OFFS_PAGE 7'h02
`define CDCS_CONN_PAGE 7'h04
`define CDCS_RES_PAGE 7'h06

// Control fields
`define CDCS_MODE_RANGE 1:0
`define CDCS_LPDLY_RANGE 3:2
`define CDCS_LAST_RANGE 7:4
`define CDCS_DECIM_RANGE 9:8
`define CDCS_SHUTDOWN_BIT 0
`define CDCS_MODE_FULL 2'h0
`define CDCS_MODE_LOW 2'h2
`define CDCS_LAST_MAX 4'h7

// Stage offset fields
`define CDCS_POS_RANGE 5:0
`define CDCS_POS_STEER_BIT 6
`define CDCS_NEG_RANGE 13:8
`define CDCS_NEG_STEER_BIT 14
`define CDCS_PAIR_BIT 15

// Threshold fields
`define CDCS_THR_LO_RANGE 15:0
`define CDCS_THR_HI_RANGE 31:16

// Reset values
`define CDCS_CTRL_RESET 16'h0000
`define CDCS_CAL_RESET 8'h00
`define CDCS_THR_RESET 32'hffff0000
`define CDCS_OFFS_RESET 16'h0000
`define CDCS_CONN_RESET 16'h0000

`endif

/* cdcs_filter_if.sv */
`timescale 1ns/100ps
interface cdcs_filter_if;
  logic sampleTick;
  logic start;
  logic [1:0] decim;
  logic busy;
  logic done;
  logic [15:0] result;

  modport filt (input sampleTick, input start, input decim,
                output busy, output done, output result);
  modport seq (output sampleTick, output start, output decim,
               input busy, input done, input result);
endinterface

/* cdcs_pkg.sv */
`include "cdcs_defines.svh"
package cdcs_pkg;

  typedef enum logic [1:0] {CDCS_OFF, CDCS_CONV, CDCS_WAIT} cdcs_state_e;
  typedef logic [9:0] cdcs_count_t;
  typedef logic [24:0] cdcs_recip_t;

  function automatic int decim_rate(input logic [1:0] decim);
    case (decim)
      2'h0: decim_rate = `CDCS_DECIM_256;
      2'h1: decim_rate = `CDCS_DECIM_128;
      default: decim_rate = `CDCS_DECIM_64;
    endcase
  endfunction

  function automatic cdcs_count_t samples_for(input logic [1:0] decim);
    samples_for = 10'(`CDCS_AVG_FACTOR * decim_rate(decim));
  endfunction

  // Full scale over sample count, so that sum * recip >> 16 spans 0..65535
  function automatic cdcs_recip_t recip_for(input logic [1:0] decim);
    recip_for = 25'((64'(`CDCS_FULL_SCALE) << `CDCS_FRAC_BITS) / 64'(samples_for(decim)));
  endfunction

endpackage

/* cdcs_result_mem.sv */
`timescale 1ns/100ps
module cdcs_result_mem #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 8,
  parameter int ADDR_W = 3
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("cdcs_result_mem: DEPTH does not fit ADDR_W");
  end

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Contents are undefined until a stage has been converted once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

/* cdcs_sample_filter.sv */
`timescale 1ns/100ps
`include "cdcs_defines.svh"
module cdcs_sample_filter (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sampleBit,
  cdcs_filter_if.filt fi
);
  cdcs_pkg::cdcs_count_t accReg;
  cdcs_pkg::cdcs_count_t cntReg;
  cdcs_pkg::cdcs_count_t targetReg;
  cdcs_pkg::cdcs_count_t accNext;
  logic [1:0] decimReg;
  logic busyReg;
  logic doneReg;
  logic lastSample;
  logic [15:0] resultReg;
  logic [34:0] scaled;

  assign accNext = accReg + {9'h0, sampleBit};
  assign lastSample = busyReg && fi.sampleTick && (cntReg == targetReg - 10'h1);
  assign scaled = 35'(accNext) * 35'(cdcs_pkg::recip_for(decimReg));

  // Start coincides with a sample tick, so that sample is the first one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accReg <= '0;
      cntReg <= '0;
      targetReg <= '0;
      decimReg <= 2'h0;
      busyReg <= 1'b0;
    end else if (fi.start) begin
      targetReg <= cdcs_pkg::samples_for(fi.decim);
      decimReg <= fi.decim;
      accReg <= {9'h0, sampleBit};
      cntReg <= 10'h1;
      busyReg <= 1'b1;
    end else if (busyReg && fi.sampleTick) begin
      accReg <= accNext;
      cntReg <= cntReg + 10'h1;
      if (lastSample) begin
        busyReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      doneReg <= 1'b0;
      resultReg <= 16'h0000;
    end else begin
      doneReg <= lastSample && !fi.start;
      if (lastSample) begin
        resultReg <= scaled[31:16];
      end
    end
  end

  assign fi.busy = busyReg;
  assign fi.done = doneReg;
  assign fi.result = resultReg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  target_map_a: assert property (fi.start |=> targetReg ==
    ($past(fi.decim) == 2'h0 ? 10'h300 : ($past(fi.decim) == 2'h1 ? 10'h180 : 10'h0c0)))
    else $error("sample target does not match decimation code");
  sample_count_a: assert property (fi.done |-> cntReg == targetReg && !busyReg)
    else $error("stage result produced after wrong number of samples");
  full_scale_a: assert property (fi.done && accReg == targetReg |-> resultReg == 16'hffff)
    else $error("all-ones input did not give full-scale code");
endmodule

/* cdcs_sensor_model.sv */
`timescale 1ns/100ps
module cdcs_sensor_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic modulatorOn,
  input wire logic sampleStrobe,
  input wire logic [15:0] connectSetup,
  output logic modulatorBit
);
  logic levelReg;

  // Idle front end gives a stream that flips every cycle, so a stale level never reads as data
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      levelReg <= 1'b0;
    end else if (!modulatorOn) begin
      levelReg <= ~levelReg;
    end else if (connectSetup[1]) begin
      // Half density: one flip per modulator sample
      if (sampleStrobe) begin
        levelReg <= ~levelReg;
      end
    end else begin
      levelReg <= connectSetup[0];
    end
  end

  assign modulatorBit = levelReg;
endmodule

/* cdcs_stage_sequencer.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "cdcs_defines.svh"
module cdcs_stage_sequencer #(
  parameter int LP_STEP_CYCLES = `CDCS_LP_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic modulatorBit,
  output logic modulatorOn,
  output logic sampleStrobe,
  output logic [2:0] activeStage,
  output logic [15:0] connectSetup,
  output logic [5:0] posOffsetCode,
  output logic posOffsetToNeg,
  output logic [5:0] negOffsetCode,
  output logic negOffsetToPos,
  output logic [7:0] calEnable,
  output logic [7:0] posActive,
  output logic [7:0] negActive,
  output logic sequenceDone
);
  localparam int SAMPLE_CYCLES = `CDCS_SAMPLE_CYCLES;
  localparam int WAIT_W = 25;

  if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 127) begin : g_bad_clock
    $error("cdcs_stage_sequencer: clock rate unsuited to sample divider");
  end
  if (LP_STEP_CYCLES < 1 || LP_STEP_CYCLES > (1 << (WAIT_W - 3))) begin : g_bad_step
    $error("cdcs_stage_sequencer: LP_STEP_CYCLES out of range");
  end

  cdcs_filter_if fi ();

  logic [15:0] ctrlReg;
  logic [7:0] calReg;
  logic [31:0] thrReg;
  logic [15:0] offsReg [8];
  logic [15:0] connReg [8];
  logic [2:0] modSync;
  logic modBitReg;
  logic [6:0] divReg;
  logic tickReg;
  cdcs_pkg::cdcs_state_e stateReg;
  logic [2:0] stageReg;
  logic [2:0] lastReg;
  logic [1:0] decimReg;
  logic [WAIT_W-1:0] waitReg;
  logic [15:0] resRdData;
  logic wrEn;
  logic [6:0] page;
  logic [2:0] idx;
  logic shutdown;
  logic [1:0] mode;
  logic [2:0] lastReq;
  logic stageStart;
  logic seqStart;
  logic stageDone;
  logic seqEnd;
  logic posHit;
  logic negHit;
  logic pairEn;
  logic stageLive;

  assign wrEn = psel && penable && pwrite;
  assign page = paddr[11:5];
  assign idx = paddr[4:2];
  assign mode = ctrlReg[`CDCS_MODE_RANGE];
  assign shutdown = mode[`CDCS_SHUTDOWN_BIT];
  // Values 8..15 collapse onto all eight stages
  assign lastReq = (ctrlReg[`CDCS_LAST_RANGE] > `CDCS_LAST_MAX) ? 3'h7
                 : ctrlReg[6:4];

  // Register writes; zero wait states, so every access phase completes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrlReg <= `CDCS_CTRL_RESET;
      calReg <= `CDCS_CAL_RESET;
      thrReg <= `CDCS_THR_RESET;
    end else if (wrEn) begin
      if (paddr == `CDCS_CTRL_ADDR) begin
        ctrlReg <= pwdata[15:0];
      end
      if (paddr == `CDCS_CAL_ADDR) begin
        calReg <= pwdata[7:0];
      end
      if (paddr == `CDCS_THR_ADDR) begin
        thrReg <= pwdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < 8; s++) begin
        offsReg[s] <= `CDCS_OFFS_RESET;
        connReg[s] <= `CDCS_CONN_RESET;
      end
    end else if (wrEn) begin
      for (int s = 0; s < 8; s++) begin
        if (page == `CDCS_OFFS_PAGE && idx == 3'(s)) begin
          offsReg[s] <= pwdata[15:0];
        end
        if (page == `CDCS_CONN_PAGE && idx == 3'(s)) begin
          connReg[s] <= pwdata[15:0];
        end
      end
    end
  end

  // Result reads are served from the memory, whose address is held since setup
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == `CDCS_CTRL_ADDR) begin
      prdata = {16'h0000, ctrlReg};
    end else if (paddr == `CDCS_CAL_ADDR) begin
      prdata = {24'h00_0000, calReg};
    end else if (paddr == `CDCS_THR_ADDR) begin
      prdata = thrReg;
    end else if (paddr == `CDCS_STAT_ADDR) begin
      prdata = {8'h00, negActive, posActive, 2'h0, fi.busy,
                stateReg == cdcs_pkg::CDCS_WAIT, stateReg == cdcs_pkg::CDCS_CONV, stageReg};
    end else if (page == `CDCS_OFFS_PAGE) begin
      prdata = {16'h0000, offsReg[idx]};
    end else if (page == `CDCS_CONN_PAGE) begin
      prdata = {16'h0000, connReg[idx]};
    end else if (page == `CDCS_RES_PAGE) begin
      prdata = {16'h0000, resRdData};
    end else begin
      pslverr = psel && penable;
    end
  end
  assign pready = 1'b1;

  // Modulator bit comes from the analog side; a change counts once two stages agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modSync <= 3'h0;
      modBitReg <= 1'b0;
    end else begin
      modSync <= {modSync[1:0], modulatorBit};
      if (modSync[1] == modSync[2]) begin
        modBitReg <= modSync[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      divReg <= 7'h00;
      tickReg <= 1'b0;
    end else begin
      tickReg <= (divReg == 7'(SAMPLE_CYCLES - 1));
      divReg <= (divReg == 7'(SAMPLE_CYCLES - 1)) ? 7'h00 : divReg + 7'h01;
    end
  end

  // A stage starts on a tick, so each stage spans exactly its sample ticks
  assign stageStart = (stateReg == cdcs_pkg::CDCS_CONV) && !shutdown && tickReg
                    && !fi.busy && !fi.done;
  assign seqStart = stageStart && (stageReg == 3'h0);
  // A result from a stage cut short by shutdown has no owner and is dropped
  assign stageDone = fi.done && (stateReg == cdcs_pkg::CDCS_CONV) && stageLive;
  assign seqEnd = stageDone && (stageReg == lastReg);

  assign fi.sampleTick = tickReg;
  assign fi.start = stageStart;
  assign fi.decim = seqStart ? ctrlReg[`CDCS_DECIM_RANGE] : decimReg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stageLive <= 1'b0;
    end else if (stateReg == cdcs_pkg::CDCS_OFF) begin
      stageLive <= 1'b0;
    end else if (stageStart) begin
      stageLive <= 1'b1;
    end else if (fi.done) begin
      stageLive <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lastReg <= 3'h0;
      decimReg <= 2'h0;
    end else if (seqStart) begin
      lastReg <= lastReq;
      decimReg <= ctrlReg[`CDCS_DECIM_RANGE];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= cdcs_pkg::CDCS_OFF;
      waitReg <= '0;
    end else if (shutdown) begin
      stateReg <= cdcs_pkg::CDCS_OFF;
    end else begin
      case (stateReg)
        cdcs_pkg::CDCS_OFF: begin
          stateReg <= cdcs_pkg::CDCS_CONV;
        end
        cdcs_pkg::CDCS_CONV: begin
          if (seqEnd && mode == `CDCS_MODE_LOW) begin
            stateReg <= cdcs_pkg::CDCS_WAIT;
            waitReg <= WAIT_W'((int'(ctrlReg[`CDCS_LPDLY_RANGE]) + 1) * LP_STEP_CYCLES - 1);
          end
        end
        cdcs_pkg::CDCS_WAIT: begin
          if (waitReg == '0 || mode == `CDCS_MODE_FULL) begin
            stateReg <= cdcs_pkg::CDCS_CONV;
          end else begin
            waitReg <= waitReg - WAIT_W'(1);
          end
        end
        default: begin
          stateReg <= cdcs_pkg::CDCS_OFF;
        end
      endcase
    end
  end

  // Full power stays in conversion; stage wraps to zero at sequence end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stageReg <= 3'h0;
    end else if (stateReg == cdcs_pkg::CDCS_OFF) begin
      stageReg <= 3'h0;
    end else if (stageDone) begin
      stageReg <= seqEnd ? 3'h0 : stageReg + 3'h1;
    end
  end

  assign pairEn = offsReg[stageReg][`CDCS_PAIR_BIT];
  assign posHit = fi.result > thrReg[`CDCS_THR_HI_RANGE];
  assign negHit = fi.result < thrReg[`CDCS_THR_LO_RANGE];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      posActive <= 8'h00;
      negActive <= 8'h00;
      sequenceDone <= 1'b0;
    end else begin
      sequenceDone <= seqEnd;
      if (stageDone) begin
        posActive[stageReg] <= posHit && !(pairEn && negHit);
        negActive[stageReg] <= negHit && !(pairEn && posHit);
      end
    end
  end

  // Front-end settings follow the current stage; they settle long before its first tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      activeStage <= 3'h0;
      connectSetup <= `CDCS_CONN_RESET;
      posOffsetCode <= 6'h00;
      posOffsetToNeg <= 1'b0;
      negOffsetCode <= 6'h00;
      negOffsetToPos <= 1'b0;
      modulatorOn <= 1'b0;
    end else begin
      activeStage <= stageReg;
      connectSetup <= connReg[stageReg];
      posOffsetCode <= offsReg[stageReg][`CDCS_POS_RANGE];
      posOffsetToNeg <= offsReg[stageReg][`CDCS_POS_STEER_BIT];
      negOffsetCode <= offsReg[stageReg][`CDCS_NEG_RANGE];
      negOffsetToPos <= offsReg[stageReg][`CDCS_NEG_STEER_BIT];
      modulatorOn <= (stateReg == cdcs_pkg::CDCS_CONV);
    end
  end
  assign sampleStrobe = tickReg;
  assign calEnable = calReg;

  cdcs_sample_filter u_filter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sampleBit(modBitReg),
    .fi(fi.filt)
  );

  cdcs_result_mem #(.DATA_W(16), .DEPTH(8), .ADDR_W(3)) u_results (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wrEn(stageDone),
    .wrAddr(stageReg),
    .wrData(fi.result),
    .rdAddr(idx),
    .rdData(resRdData)
  );

  // Checking helpers: cycles since the stage and the sequence began
  logic [15:0] stageCyc;
  logic [19:0] seqCyc;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stageCyc <= '0;
      seqCyc <= '0;
    end else begin
      stageCyc <= stageStart ? 16'h0001 : stageCyc + 16'h0001;
      seqCyc <= seqStart ? 20'h00001 : seqCyc + 20'h00001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_seq_end_full;
    seqEnd && mode == `CDCS_MODE_FULL;
  endsequence
  sequence s_next_start;
    ##[1:81] seqStart;
  endsequence

  tick_period_a: assert property (tickReg |-> ##SAMPLE_CYCLES tickReg)
    else $error("sample tick period wrong");
  stage_time_a: assert property (stageDone |-> 32'(stageCyc) ==
    (cdcs_pkg::decim_rate(decimReg) * 3 - 1) * SAMPLE_CYCLES + 1)
    else $error("stage duration wrong");
  seq_time_a: assert property (seqEnd && !seqStart |-> 32'(seqCyc) ==
    ((int'(lastReg) + 1) * cdcs_pkg::decim_rate(decimReg) * 3 - 1) * SAMPLE_CYCLES + 1)
    else $error("sequence duration wrong");
  stage_ascend_a: assert property (stageDone && !seqEnd && !shutdown |=>
    stageReg == $past(stageReg) + 3'h1)
    else $error("stage did not advance by one");
  stage_wrap_a: assert property (seqEnd |=> stageReg == 3'h0)
    else $error("sequence did not return to stage zero");
  full_restart_a: assert property (s_seq_end_full and !shutdown ##1
    (!shutdown && mode == `CDCS_MODE_FULL)[*2] |-> s_next_start)
    else $error("full power did not restart sequence");
  shutdown_off_a: assert property (shutdown |=> stateReg == cdcs_pkg::CDCS_OFF)
    else $error("shutdown mode did not stop conversion");
  lp_delay_a: assert property ($rose(stateReg == cdcs_pkg::CDCS_WAIT) |->
    32'(waitReg) == (int'($past(ctrlReg[3:2])) + 1) * LP_STEP_CYCLES - 1)
    else $error("low power idle delay wrong");
  seq_latch_a: assert property (!seqStart |=> $stable(lastReg) && $stable(decimReg))
    else $error("sequence settings changed mid-sequence");
  last_clamp_a: assert property (seqStart && ctrlReg[7:4] > 4'h7 |=> lastReg == 3'h7)
    else $error("last stage above seven not clamped");
  pair_reject_a: assert property (stageDone && pairEn && posHit && negHit |=>
    !posActive[$past(stageReg)] && !negActive[$past(stageReg)])
    else $error("paired buttons both reported");
endmodule

/* cdcs_stage_sequencer_test.sv */
`timescale 1ns/100ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (x)); end end
module cdcs_stage_sequencer_test;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} cdcs_row_s;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, modulatorBit, modulatorOn, sampleStrobe, sequenceDone;
  logic [2:0] activeStage;
  logic [15:0] connectSetup;
  logic [5:0] posOffsetCode, negOffsetCode;
  logic posOffsetToNeg, negOffsetToPos;
  logic [7:0] calEnable, posActive, negActive;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int tA, tB, i;
  cdcs_row_s rows [8];

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Short idle step keeps the low power wait inside the run
  cdcs_stage_sequencer #(.LP_STEP_CYCLES(20)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .modulatorBit(modulatorBit),
    .modulatorOn(modulatorOn), .sampleStrobe(sampleStrobe), .activeStage(activeStage),
    .connectSetup(connectSetup), .posOffsetCode(posOffsetCode),
    .posOffsetToNeg(posOffsetToNeg), .negOffsetCode(negOffsetCode),
    .negOffsetToPos(negOffsetToPos), .calEnable(calEnable), .posActive(posActive),
    .negActive(negActive), .sequenceDone(sequenceDone));

  cdcs_sensor_model model (.clk_sys(clk_sys), .arst_n(arst_n), .modulatorOn(modulatorOn),
    .sampleStrobe(sampleStrobe), .connectSetup(connectSetup), .modulatorBit(modulatorBit));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Kind 0: second stage active, 1: sequence done pulse, 2: converting
  task automatic wait_sig(input int k);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(negedge clk_sys);
      if ((k == 0 && activeStage === 3'h1) || (k == 1 && sequenceDone === 1'b1) ||
          (k == 2 && modulatorOn === 1'b1)) break;
    end
    if (n == 20000) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, k, 1);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    n_fail++;
    close_out();
  end

  initial begin
    rows = '{'{12'h004, 32'h3, 32'h3, 1'b0}, '{12'h008, 32'h80004000, 32'h80004000, 1'b0},
             '{12'h040, 32'h156a, 32'h156a, 1'b0}, '{12'h044, 32'h4005, 32'h4005, 1'b0},
             '{12'h080, 32'h1, 32'h1, 1'b0}, '{12'h084, 32'h10, 32'h10, 1'b0},
             '{12'h00c, 32'h1234, 32'h0, 1'b0}, '{12'h3fc, 32'h5, 32'h0, 1'b1}};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 12'h000, 32'h0, q, e);
    `CHK(q, 32'h0)
    apb(1'b0, 12'h008, 32'h0, q, e);
    `CHK(q, 32'hffff0000)
    apb(1'b1, 12'h000, 32'h1, q, e);
    repeat (3) @(negedge clk_sys);
    `CHK(modulatorOn, 1'b0)
    $display("test reset and shutdown done");
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, rows[i].a, rows[i].w, q, e);
      apb(1'b0, rows[i].a, 32'h0, q, e);
      `CHK(q, rows[i].r)
      `CHK(e, rows[i].e)
    end
    `CHK(calEnable, 8'h03)
    $display("test register rows done");
    // Two stages at decimation 64, low power idle delay 400 ms for later
    apb(1'b1, 12'h000, 32'h214, q, e);
    wait_sig(0);
    tA = cyc;
    repeat (2) @(negedge clk_sys);
    `CHK(posActive[0], 1'b1)
    `CHK(connectSetup, 16'h0010)
    `CHK({posOffsetCode, posOffsetToNeg, negOffsetCode, negOffsetToPos}, 14'h0501)
    @(posedge clk_sys);
    apb(1'b0, 12'h0c0, 32'h0, q, e);
    `CHK(q, 32'hffff)
    apb(1'b1, 12'h000, 32'h206, q, e);
    apb(1'b1, 12'h080, 32'h2, q, e);
    apb(1'b1, 12'h040, 32'h956a, q, e);
    apb(1'b1, 12'h008, 32'h0000ffff, q, e);
    wait_sig(1);
    tB = cyc;
    `CHK(tB - tA, 15359)
    `CHK(negActive[1], 1'b1)
    @(posedge clk_sys);
    apb(1'b0, 12'h0c4, 32'h0, q, e);
    `CHK(q, 32'h0)
    $display("test first sequence done");
    wait_sig(2);
    tA = cyc;
    `CHK(tA - tB >= 36 && tA - tB <= 44, 1'b1)
    repeat (4) @(negedge clk_sys);
    `CHK(activeStage, 3'h0)
    `CHK({posOffsetCode, posOffsetToNeg, negOffsetCode, negOffsetToPos}, 14'h2aaa)
    wait_sig(1);
    tB = cyc;
    `CHK(tB - tA >= 15281 && tB - tA <= 15360, 1'b1)
    `CHK({posActive[0], negActive[0]}, 2'b00)
    @(posedge clk_sys);
    apb(1'b0, 12'h0c0, 32'h0, q, e);
    `CHK(q, 32'h7fff)
    $display("test low power sequence done");
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(negedge clk_sys);
    `CHK(modulatorOn, 1'b0)
    `CHK(pready, 1'b1)
    @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 12'h000, 32'h0, q, e);
    `CHK(q, 32'h0)
    $display("test mid-run reset done");
    close_out();
  end
endmodule
